/* File: rtl/tpc_timer_pair.sv */
// Timer pair with APB registers, chaining, debug halt and interrupts.
// Operation
// - Debug halt freezes half when enabled
// - Trigger output driven only when enabled
// - Wait-on-trigger holds start until predecessor timeout
// - Controls set per half or both
// - Seven interrupt sources at fixed bits
// - Capture flags separate per half
// - Interrupt is OR of masked pending
// - Mask written freely in one access
// - Raw and masked status both readable
// - Clear named flags, others unchanged
// - Load read returns programmed value
// - Full load readable in one access
// - Capture edge rising, falling or both
// - Load write reloads running counter immediately
module tpc_timer_pair (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        dbg_halt,
  input  wire logic        cap_a_in,
  input  wire logic        cap_b_in,
  input  wire logic        chain_trig_in,
  output logic             trig_a_out,
  output logic             trig_b_out,
  output logic             irq
);
  tpc_pkg::tpc_top_st_t   st_r;     // Registered state.
  tpc_pkg::tpc_top_st_t   st_nxt;   // Next state.
  logic [tpc_pkg::HW-1:0] cnt_a;    // First half count.
  logic [tpc_pkg::HW-1:0] cnt_b;    // Second half count.
  tpc_pkg::tpc_half_evt_t evt_a;    // First half events.
  tpc_pkg::tpc_half_evt_t evt_b;    // Second half events.
  logic                   wr;       // Write access phase.
  logic                   rd_setup; // Read setup phase.
  logic                   mapped;   // Address decodes to a register.
  logic                   ld_a;     // Counter load, first half.
  logic                   ld_b;     // Counter load, second half.
  logic                   run_en_a; // First half allowed to count.
  logic                   run_en_b; // Second half allowed to count.
  logic                   masked_view_select; // Status read shows masked view.
  logic [31:0]            ctrl_rd;  // Control word as read.
  logic [31:0]            ctrl_w;   // Control word after a write.
  logic [31:0]            rd_mux;   // Read data selected by address.
  logic [tpc_pkg::IW-1:0] ev;       // Events raised this cycle.

  // Bus phase decode and address map.
  always_comb begin
    wr       = psel & penable & pwrite;
    rd_setup = psel & ~penable & ~pwrite;
    case (paddr)
      tpc_pkg::OFS_CTRL, tpc_pkg::OFS_CTRL_SET, tpc_pkg::OFS_CTRL_CLR,
      tpc_pkg::OFS_LOAD_A, tpc_pkg::OFS_LOAD_B, tpc_pkg::OFS_VAL_A,
      tpc_pkg::OFS_VAL_B, tpc_pkg::OFS_MATCH_A, tpc_pkg::OFS_MATCH_B,
      tpc_pkg::OFS_IMASK, tpc_pkg::OFS_RIS, tpc_pkg::OFS_MIS,
      tpc_pkg::OFS_ICLR: mapped = 1'b1;
      default:           mapped = 1'b0;
    endcase
    // In joined mode the first half location carries the whole value.
    ld_a = wr & (paddr == tpc_pkg::OFS_LOAD_A);
    ld_b = wr & ((paddr == tpc_pkg::OFS_LOAD_B) | (ld_a & st_r.joined));
    masked_view_select = (paddr == tpc_pkg::OFS_MIS);
  end

  // Run gating: enable, debug freeze and wait-on-trigger.
  always_comb begin
    run_en_a = st_r.cfg_a.run & ~st_r.waiting_a
             & ~(st_r.cfg_a.halt_on_debug & dbg_halt);
    // Joined mode drives both halves from the first half controls.
    if (st_r.joined) begin
      run_en_b = run_en_a;
    end else begin
      run_en_b = st_r.cfg_b.run & ~st_r.waiting_b
               & ~(st_r.cfg_b.halt_on_debug & dbg_halt);
    end
  end

  // The first half is the low word when the halves are joined.
  tpc_half u_half_a (
    .clk        (clk),
    .srst       (srst),
    .run_en     (run_en_a),
    .step_ok    (1'b1),
    .capture    (st_r.cfg_a.capture & ~st_r.joined),
    .edge_sel   (st_r.cfg_a.edge_sel),
    .cap_in     (cap_a_in),
    .wrap_en    (st_r.joined & (cnt_b != '0)),
    .reload_val (st_r.load_a),
    .load_wr    (ld_a),
    .wr_val     (pwdata[15:0]),
    .match_val  (st_r.match_a),
    .cnt        (cnt_a),
    .evt        (evt_a)
  );

  // The second half steps on the first half's borrow when joined.
  tpc_half u_half_b (
    .clk        (clk),
    .srst       (srst),
    .run_en     (run_en_b),
    .step_ok    (~st_r.joined | evt_a.borrow),
    .capture    (st_r.cfg_b.capture & ~st_r.joined),
    .edge_sel   (st_r.cfg_b.edge_sel),
    .cap_in     (cap_b_in),
    .wrap_en    (1'b0),
    .reload_val (st_r.load_b),
    .load_wr    (ld_b),
    .wr_val     (st_r.joined ? pwdata[31:16] : pwdata[15:0]),
    .match_val  (st_r.match_b),
    .cnt        (cnt_b),
    .evt        (evt_b)
  );

  // Event vector in the shared interrupt bit layout.
  always_comb begin
    ev = '0;
    // A joined timeout needs both halves at zero together.
    ev[tpc_pkg::I_TO_A] = evt_a.timeout & (~st_r.joined | (cnt_b == '0));
    ev[tpc_pkg::I_CM_A] = evt_a.cap_match;
    ev[tpc_pkg::I_CE_A] = evt_a.cap_event;
    ev[tpc_pkg::I_TO_B] = evt_b.timeout & ~st_r.joined;
    ev[tpc_pkg::I_CM_B] = evt_b.cap_match;
    ev[tpc_pkg::I_CE_B] = evt_b.cap_event;
    // Clock match only counts in joined clock mode while running.
    ev[tpc_pkg::I_CLK] = st_r.joined & st_r.clock_mode & run_en_a
                       & ({cnt_b, cnt_a} == {st_r.match_b, st_r.match_a});
  end

  // Control word packing, for reads and for read-modify writes.
  always_comb begin
    ctrl_rd = '0;
    ctrl_rd[tpc_pkg::C_A +: tpc_pkg::C_W] = st_r.cfg_a;
    ctrl_rd[tpc_pkg::C_B +: tpc_pkg::C_W] = st_r.cfg_b;
    ctrl_rd[tpc_pkg::C_JOIN] = st_r.joined;
    ctrl_rd[tpc_pkg::C_CLK]  = st_r.clock_mode;
    // Set and clear aliases touch one half, the other, or both.
    case (paddr)
      tpc_pkg::OFS_CTRL:     ctrl_w = pwdata;
      tpc_pkg::OFS_CTRL_SET: ctrl_w = ctrl_rd | pwdata;
      tpc_pkg::OFS_CTRL_CLR: ctrl_w = ctrl_rd & ~pwdata;
      default:               ctrl_w = ctrl_rd;
    endcase
  end

  // Read data mux, sampled in the setup phase.
  always_comb begin
    case (paddr)
      tpc_pkg::OFS_CTRL:    rd_mux = ctrl_rd;
      tpc_pkg::OFS_LOAD_A:  rd_mux = st_r.joined ? {st_r.load_b, st_r.load_a}
                                                 : {16'h0000, st_r.load_a};
      tpc_pkg::OFS_LOAD_B:  rd_mux = {16'h0000, st_r.load_b};
      tpc_pkg::OFS_VAL_A:   rd_mux = st_r.joined ? {cnt_b, cnt_a} : {16'h0000, cnt_a};
      tpc_pkg::OFS_VAL_B:   rd_mux = {16'h0000, cnt_b};
      tpc_pkg::OFS_MATCH_A: rd_mux = {16'h0000, st_r.match_a};
      tpc_pkg::OFS_MATCH_B: rd_mux = {16'h0000, st_r.match_b};
      tpc_pkg::OFS_IMASK:   rd_mux = {21'h00_0000, st_r.mask};
      tpc_pkg::OFS_RIS, tpc_pkg::OFS_MIS: begin
        // One mux serves both views; only the mask term differs.
        rd_mux = {21'h00_0000, st_r.ris & (masked_view_select ? st_r.mask : '1)};
      end
      default:              rd_mux = '0;
    endcase
  end

  // Next state: register writes, wait arming, flags and outputs.
  always_comb begin
    st_nxt = st_r;
    if (wr) begin
      case (paddr)
        tpc_pkg::OFS_CTRL, tpc_pkg::OFS_CTRL_SET, tpc_pkg::OFS_CTRL_CLR: begin
          st_nxt.cfg_a      = ctrl_w[tpc_pkg::C_A +: tpc_pkg::C_W];
          st_nxt.cfg_b      = ctrl_w[tpc_pkg::C_B +: tpc_pkg::C_W];
          st_nxt.joined     = ctrl_w[tpc_pkg::C_JOIN];
          st_nxt.clock_mode = ctrl_w[tpc_pkg::C_CLK];
        end
        tpc_pkg::OFS_LOAD_A: begin
          st_nxt.load_a = pwdata[15:0];
          if (st_r.joined) begin
            st_nxt.load_b = pwdata[31:16];
          end
        end
        tpc_pkg::OFS_LOAD_B:  st_nxt.load_b  = pwdata[15:0];
        tpc_pkg::OFS_MATCH_A: begin
          st_nxt.match_a = pwdata[15:0];
          if (st_r.joined) begin
            st_nxt.match_b = pwdata[31:16];
          end
        end
        tpc_pkg::OFS_MATCH_B: st_nxt.match_b = pwdata[15:0];
        tpc_pkg::OFS_IMASK:   st_nxt.mask    = pwdata[tpc_pkg::IW-1:0];
        default: begin
        end
      endcase
    end
    // A fresh enable with wait set parks the half; disabling drops it.
    if (!st_nxt.cfg_a.run) begin
      st_nxt.waiting_a = 1'b0;
    end else if (!st_r.cfg_a.run && st_nxt.cfg_a.wait_for_chain_trigger) begin
      st_nxt.waiting_a = 1'b1;
    end else if (chain_trig_in) begin
      st_nxt.waiting_a = 1'b0;
    end
    // The second half waits on the first half's timeout.
    if (!st_nxt.cfg_b.run) begin
      st_nxt.waiting_b = 1'b0;
    end else if (!st_r.cfg_b.run && st_nxt.cfg_b.wait_for_chain_trigger) begin
      st_nxt.waiting_b = 1'b1;
    end else if (evt_a.timeout) begin
      st_nxt.waiting_b = 1'b0;
    end
    // New events beat a clear in the same cycle, so none is lost.
    st_nxt.ris = st_r.ris | ev;
    if (wr && paddr == tpc_pkg::OFS_ICLR) begin
      st_nxt.ris = (st_r.ris & ~pwdata[tpc_pkg::IW-1:0]) | ev;
    end
    // The pin follows the next flags, so it never trails the status.
    st_nxt.irq    = |(st_nxt.ris & st_nxt.mask);
    // Triggers pulse once, one edge after the timeout they report.
    st_nxt.trig_a = st_r.cfg_a.trigger_out_enable & ev[tpc_pkg::I_TO_A];
    st_nxt.trig_b = st_r.cfg_b.trigger_out_enable & ev[tpc_pkg::I_TO_B];
    if (rd_setup) begin
      st_nxt.prdata = rd_mux;
    end
  end

  // State register; all controls start disabled.
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r         <= '0;
      st_r.load_a  <= tpc_pkg::LOAD_RST;
      st_r.load_b  <= tpc_pkg::LOAD_RST;
      st_r.match_a <= tpc_pkg::MATCH_RST;
      st_r.match_b <= tpc_pkg::MATCH_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // The slave never stalls, so every access takes exactly two cycles.
  assign pready     = 1'b1;
  // Unmapped offsets flag an error but change no state.
  assign pslverr    = psel & penable & ~mapped;
  assign prdata     = st_r.prdata;
  assign trig_a_out = st_r.trig_a;
  assign trig_b_out = st_r.trig_b;
  assign irq        = st_r.irq;

  // All checks share the one clock and stay quiet while reset is held.
  // They read registered state, so a bus write shows one edge later.
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // Interrupt flags: the pin, the clear and the stickiness.
  property p_irq_or;
    irq == |(st_r.ris & st_r.mask);
  endproperty
  a_irq_or: assert property (p_irq_or) else $error("irq not masked OR");

  property p_clear;
    wr && paddr == tpc_pkg::OFS_ICLR
      |=> (st_r.ris & $past(pwdata[tpc_pkg::IW-1:0]) & ~$past(ev)) == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("cleared flag remained");

  property p_sticky;
    !(wr && paddr == tpc_pkg::OFS_ICLR) |=> ($past(st_r.ris) & ~st_r.ris) == '0;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped uncleared");

  property p_set;
    |ev |=> (st_r.ris & $past(ev)) == $past(ev);
  endproperty
  a_set: assert property (p_set) else $error("event not latched");

  // Gated activity: debug halt, trigger gating, chain wait and stop.
  property p_halt;
    st_r.cfg_a.halt_on_debug && dbg_halt && !ld_a |=> $stable(cnt_a);
  endproperty
  a_halt: assert property (p_halt) else $error("count moved in debug");

  property p_trig_off;
    !st_r.cfg_a.trigger_out_enable |=> !trig_a_out;
  endproperty
  a_trig_off: assert property (p_trig_off) else $error("trigger while off");

  property p_trig_b_off;
    !st_r.cfg_b.trigger_out_enable |=> !trig_b_out;
  endproperty
  a_trig_b_off: assert property (p_trig_b_off) else $error("trigger b while off");

  property p_wait;
    st_r.waiting_a && !ld_a |=> $stable(cnt_a);
  endproperty
  a_wait: assert property (p_wait) else $error("counted while waiting");

  property p_wait_b;
    st_r.waiting_b && !st_r.joined && !ld_b |=> $stable(cnt_b);
  endproperty
  a_wait_b: assert property (p_wait_b) else $error("b counted while waiting");

  property p_stop;
    !st_r.cfg_b.run && !st_r.joined && !ld_b
      |-> !ev[tpc_pkg::I_TO_B] && !ev[tpc_pkg::I_CE_B] ##1 $stable(cnt_b);
  endproperty
  a_stop: assert property (p_stop) else $error("disabled half active");

  // Loads land at the access edge, whether the half runs or not.
  property p_load_now;
    ld_a && !st_r.joined |=> cnt_a == $past(pwdata[15:0]);
  endproperty
  a_load_now: assert property (p_load_now) else $error("load not immediate");

  property p_load_b_now;
    ld_b && !st_r.joined |=> cnt_b == $past(pwdata[15:0]);
  endproperty
  a_load_b_now: assert property (p_load_b_now) else $error("b load not immediate");

  property p_mis_rd;
    rd_setup && paddr == tpc_pkg::OFS_MIS
      |=> prdata[tpc_pkg::IW-1:0] == $past(st_r.ris & st_r.mask);
  endproperty
  a_mis_rd: assert property (p_mis_rd) else $error("masked view wrong");

  // Scenarios that a full run should reach at least once.
  c_irq_seen: cover property (!irq ##1 irq);
  c_chain:    cover property (st_r.waiting_b ##1 !st_r.waiting_b && st_r.cfg_b.run);
  c_capture:  cover property (ev[tpc_pkg::I_CM_A]);
  c_joined:   cover property (st_r.joined && ev[tpc_pkg::I_TO_A]);
  c_clock:    cover property (ev[tpc_pkg::I_CLK]);
endmodule

/* File: rtl/tpc_pkg.sv */
// Shared constants and types for the timer pair block.
package tpc_pkg;
  // Width of one half timer; the joined counter is twice this.
  localparam int unsigned HW = 16;
  // Register byte offsets on the APB.
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_CTRL_SET = 8'h04;
  localparam logic [7:0] OFS_CTRL_CLR = 8'h08;
  localparam logic [7:0] OFS_LOAD_A   = 8'h0c;
  localparam logic [7:0] OFS_LOAD_B   = 8'h10;
  localparam logic [7:0] OFS_VAL_A    = 8'h14;
  localparam logic [7:0] OFS_VAL_B    = 8'h18;
  localparam logic [7:0] OFS_MATCH_A  = 8'h1c;
  localparam logic [7:0] OFS_MATCH_B  = 8'h20;
  localparam logic [7:0] OFS_IMASK    = 8'h24;
  localparam logic [7:0] OFS_RIS      = 8'h28;
  localparam logic [7:0] OFS_MIS      = 8'h2c;
  localparam logic [7:0] OFS_ICLR     = 8'h30;
  // Control word layout: first half at bit 0, second half at bit 8.
  localparam int unsigned C_A    = 0;
  localparam int unsigned C_B    = 8;
  localparam int unsigned C_W    = 7;
  localparam int unsigned C_JOIN = 16;
  localparam int unsigned C_CLK  = 17;
  // Interrupt source bit positions, shared by mask, raw, masked and clear.
  localparam int unsigned I_TO_A = 0;
  localparam int unsigned I_CM_A = 1;
  localparam int unsigned I_CE_A = 2;
  localparam int unsigned I_CLK  = 3;
  localparam int unsigned I_TO_B = 8;
  localparam int unsigned I_CM_B = 9;
  localparam int unsigned I_CE_B = 10;
  localparam int unsigned IW     = 11;
  // Capture edge codes; code 2'b10 also counts both edges.
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  // Values after reset.
  localparam logic [HW-1:0] LOAD_RST = 16'hffff;
  localparam logic [HW-1:0] MATCH_RST = 16'h0000;
  // Per-half controls, packed in the order of the control word bits.
  typedef struct packed {
    logic       capture;
    logic [1:0] edge_sel;
    logic       wait_for_chain_trigger;
    logic       trigger_out_enable;
    logic       halt_on_debug;
    logic       run;
  } tpc_half_cfg_t;
  // Per-cycle events reported by one half.
  typedef struct packed {
    logic timeout;
    logic cap_event;
    logic cap_match;
    logic borrow;
  } tpc_half_evt_t;
  // Whole state of one half timer.
  typedef struct packed {
    logic [HW-1:0] cnt;
    logic          cap_q;
  } tpc_half_st_t;
  // Whole state of the block top.
  typedef struct packed {
    tpc_half_cfg_t cfg_a;
    tpc_half_cfg_t cfg_b;
    logic          joined;
    logic          clock_mode;
    logic [HW-1:0] load_a;
    logic [HW-1:0] load_b;
    logic [HW-1:0] match_a;
    logic [HW-1:0] match_b;
    logic [IW-1:0] mask;
    logic [IW-1:0] ris;
    logic          waiting_a;
    logic          waiting_b;
    logic          trig_a;
    logic          trig_b;
    logic          irq;
    logic [31:0]   prdata;
  } tpc_top_st_t;
endpackage

/* File: rtl/tpc_half.sv */
// One half timer: down counter with reload, wrap and edge capture.
module tpc_half (
  input  wire logic                    clk,
  input  wire logic                    srst,
  input  wire logic                    run_en,
  input  wire logic                    step_ok,
  input  wire logic                    capture,
  input  wire logic [1:0]              edge_sel,
  input  wire logic                    cap_in,
  input  wire logic                    wrap_en,
  input  wire logic [tpc_pkg::HW-1:0]  reload_val,
  input  wire logic                    load_wr,
  input  wire logic [tpc_pkg::HW-1:0]  wr_val,
  input  wire logic [tpc_pkg::HW-1:0]  match_val,
  output logic      [tpc_pkg::HW-1:0]  cnt,
  output tpc_pkg::tpc_half_evt_t       evt
);
  tpc_pkg::tpc_half_st_t st_r;   // Registered state.
  tpc_pkg::tpc_half_st_t st_nxt; // Next state.
  logic                  hit;    // Selected capture edge seen.
  logic                  step;   // Counter moves this cycle.
  logic [tpc_pkg::HW-1:0] dec;   // Count minus one.

  // Edge pick, step decision, and the next count.
  always_comb begin
    st_nxt = st_r;
    dec    = st_r.cnt - 1'b1;
    case (edge_sel)
      tpc_pkg::EDGE_RISE: hit = cap_in & ~st_r.cap_q;
      tpc_pkg::EDGE_FALL: hit = ~cap_in & st_r.cap_q;
      default:            hit = cap_in ^ st_r.cap_q;
    endcase
    // A disabled or frozen half does not move and reports nothing.
    step = capture ? (run_en & hit) : (run_en & step_ok);
    evt.borrow    = step & (st_r.cnt == '0);
    evt.timeout   = evt.borrow & ~capture;
    evt.cap_event = run_en & capture & hit;
    evt.cap_match = step & capture & (dec == match_val);
    st_nxt.cap_q = cap_in;
    // A software load overrides counting, even while running.
    if (load_wr) begin
      st_nxt.cnt = wr_val;
    end else if (step) begin
      if (st_r.cnt == '0) begin
        st_nxt.cnt = wrap_en ? '1 : reload_val;
      end else begin
        st_nxt.cnt = dec;
      end
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r.cnt   <= tpc_pkg::LOAD_RST;
      st_r.cap_q <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cnt = st_r.cnt;
endmodule

/* File: dv/testbench.sv */
// Self-checking testbench for the timer pair block.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // One register access: direction, offset, write data, expected read, expected error.
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] exp;
    logic        err;
  } tpc_row_t;
  logic        clk;
  logic        srst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        dbg_halt;
  logic        cap_a_in;
  logic        cap_b_in;
  logic        chain_trig_in;
  logic        trig_a_out;
  logic        trig_b_out;
  logic        irq;
  int          err_total = 0;
  int          n_tests = 0;
  int          n_trig_a = 0;
  int          n_trig_b = 0;
  logic [31:0] rd;
  logic [31:0] v1;
  logic        se;
  // Plain register cases; reset values first, then read-back, an ignored status write and an unmapped read.
  tpc_row_t rows [16] = '{
    '{1'b0, tpc_pkg::OFS_LOAD_A, 32'h0000_0000, 32'h0000_ffff, 1'b0},
    '{1'b0, tpc_pkg::OFS_CTRL, 32'h0000_0000, 32'h0000_0000, 1'b0},
    '{1'b0, tpc_pkg::OFS_RIS, 32'h0000_0000, 32'h0000_0000, 1'b0},
    '{1'b1, tpc_pkg::OFS_IMASK, 32'h0000_070f, 32'h0000_0000, 1'b0},
    '{1'b0, tpc_pkg::OFS_IMASK, 32'h0000_0000, 32'h0000_070f, 1'b0},
    '{1'b0, tpc_pkg::OFS_MIS, 32'h0000_0000, 32'h0000_0000, 1'b0},
    '{1'b1, tpc_pkg::OFS_RIS, 32'h0000_070f, 32'h0000_0000, 1'b0},
    '{1'b0, tpc_pkg::OFS_RIS, 32'h0000_0000, 32'h0000_0000, 1'b0},
    '{1'b1, tpc_pkg::OFS_CTRL_SET, 32'h0000_0202, 32'h0000_0000, 1'b0},
    '{1'b1, tpc_pkg::OFS_CTRL_CLR, 32'h0000_0002, 32'h0000_0000, 1'b0},
    '{1'b0, tpc_pkg::OFS_CTRL, 32'h0000_0000, 32'h0000_0200, 1'b0},
    '{1'b1, tpc_pkg::OFS_CTRL_CLR, 32'h0000_0200, 32'h0000_0000, 1'b0},
    '{1'b1, tpc_pkg::OFS_IMASK, 32'h0000_0000, 32'h0000_0000, 1'b0},
    '{1'b0, 8'h40, 32'h0000_0000, 32'h0000_0000, 1'b1},
    '{1'b1, tpc_pkg::OFS_LOAD_B, 32'h0000_1234, 32'h0000_0000, 1'b0},
    '{1'b0, tpc_pkg::OFS_LOAD_B, 32'h0000_0000, 32'h0000_1234, 1'b0}
  };

  tpc_timer_pair u_tpc_timer_pair (
    .clk           (clk),
    .srst          (srst),
    .psel          (psel),
    .penable       (penable),
    .pwrite        (pwrite),
    .paddr         (paddr),
    .pwdata        (pwdata),
    .prdata        (prdata),
    .pready        (pready),
    .pslverr       (pslverr),
    .dbg_halt      (dbg_halt),
    .cap_a_in      (cap_a_in),
    .cap_b_in      (cap_b_in),
    .chain_trig_in (chain_trig_in),
    .trig_a_out    (trig_a_out),
    .trig_b_out    (trig_b_out),
    .irq           (irq)
  );

  // Free-running 50 MHz clock.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Counts trigger pulses so scenarios can see whether any left the block.
  always @(posedge clk) begin
    if (trig_a_out === 1'b1) n_trig_a++;
    if (trig_b_out === 1'b1) n_trig_b++;
  end

  // Compares a register word.
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Compares a single output bit.
  task automatic chk1(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; entered just after a rising edge, held until pready is seen.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // An idle edge before the next request.
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, se);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000, rd, se);
    chk32(rd, exp);
  endtask

  // Polls raw status until all bits of m are up, with a bounded number of reads.
  task automatic wait_ris(input logic [31:0] m);
    int k;
    k = 0;
    do begin
      apb(1'b0, tpc_pkg::OFS_RIS, 32'h0000_0000, rd, se);
      k++;
    end while ((rd & m) !== m && k < 200);
  endtask

  task automatic tally_and_finish();
    if (err_total == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Watchdog: the whole run needs far less than this span.
  initial begin
    #400000;
    err_total++;
    tally_and_finish();
  end

  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    dbg_halt = 1'b0;
    cap_a_in = 1'b0;
    cap_b_in = 1'b0;
    chain_trig_in = 1'b0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].addr, rows[i].wdata, rd, se);
      if (!rows[i].wr) chk32(rd, rows[i].exp);
      chk1(se, rows[i].err);
    end
    // Both halves time out with triggers on, then are stopped and inspected.
    wr(tpc_pkg::OFS_LOAD_A, 32'h0000_0003);
    wr(tpc_pkg::OFS_LOAD_B, 32'h0000_0005);
    wr(tpc_pkg::OFS_IMASK, 32'h0000_0101);
    wr(tpc_pkg::OFS_CTRL_SET, 32'h0000_0505);
    wait_ris(32'h0000_0101);
    wr(tpc_pkg::OFS_CTRL_CLR, 32'h0000_0101);
    rdc(tpc_pkg::OFS_LOAD_A, 32'h0000_0003);
    chk1(n_trig_a > 0 && n_trig_b > 0, 1'b1);
    chk1(irq, 1'b1);
    apb(1'b0, tpc_pkg::OFS_VAL_A, 32'h0000_0000, v1, se);
    repeat (4) @(posedge clk);
    rdc(tpc_pkg::OFS_VAL_A, v1);
    wr(tpc_pkg::OFS_IMASK, 32'h0000_0100);
    repeat (2) @(posedge clk);
    chk1(irq, 1'b1);
    rdc(tpc_pkg::OFS_MIS, 32'h0000_0100);
    wr(tpc_pkg::OFS_IMASK, 32'h0000_0000);
    repeat (2) @(posedge clk);
    chk1(irq, 1'b0);
    rdc(tpc_pkg::OFS_RIS, 32'h0000_0101);
    wr(tpc_pkg::OFS_ICLR, 32'h0000_0001);
    rdc(tpc_pkg::OFS_RIS, 32'h0000_0100);
    wr(tpc_pkg::OFS_ICLR, 32'h0000_0100);
    rdc(tpc_pkg::OFS_RIS, 32'h0000_0000);
    // With the trigger enables cleared, a timeout must not pulse either output.
    wr(tpc_pkg::OFS_CTRL_CLR, 32'h0000_0404);
    n_trig_a = 0;
    n_trig_b = 0;
    wr(tpc_pkg::OFS_LOAD_A, 32'h0000_0002);
    wr(tpc_pkg::OFS_CTRL_SET, 32'h0000_0001);
    wait_ris(32'h0000_0001);
    wr(tpc_pkg::OFS_CTRL_CLR, 32'h0000_0001);
    chk1(n_trig_a == 0 && n_trig_b == 0, 1'b1);
    wr(tpc_pkg::OFS_ICLR, 32'h0000_07ff);
    // Debug halt: frozen while set, counting when released or when the control is off.
    wr(tpc_pkg::OFS_CTRL_SET, 32'h0000_0002);
    dbg_halt <= 1'b1;
    wr(tpc_pkg::OFS_CTRL_SET, 32'h0000_0001);
    wr(tpc_pkg::OFS_LOAD_A, 32'h0000_0100);
    repeat (5) @(posedge clk);
    rdc(tpc_pkg::OFS_VAL_A, 32'h0000_0100);
    dbg_halt <= 1'b0;
    repeat (3) @(posedge clk);
    apb(1'b0, tpc_pkg::OFS_VAL_A, 32'h0000_0000, v1, se);
    chk1(v1 < 32'h0000_0100, 1'b1);
    wr(tpc_pkg::OFS_CTRL_CLR, 32'h0000_0002);
    dbg_halt <= 1'b1;
    apb(1'b0, tpc_pkg::OFS_VAL_A, 32'h0000_0000, v1, se);
    repeat (3) @(posedge clk);
    apb(1'b0, tpc_pkg::OFS_VAL_A, 32'h0000_0000, rd, se);
    chk1(rd != v1, 1'b1);
    wr(tpc_pkg::OFS_CTRL_CLR, 32'h0000_0001);
    dbg_halt <= 1'b0;
    wr(tpc_pkg::OFS_ICLR, 32'h0000_07ff);
    // Chained start: both halves wait; only the external pulse lets the chain go.
    wr(tpc_pkg::OFS_LOAD_A, 32'h0000_0002);
    wr(tpc_pkg::OFS_LOAD_B, 32'h0000_0004);
    wr(tpc_pkg::OFS_CTRL_SET, 32'h0000_0808);
    wr(tpc_pkg::OFS_CTRL_SET, 32'h0000_0101);
    repeat (10) @(posedge clk);
    rdc(tpc_pkg::OFS_VAL_A, 32'h0000_0002);
    rdc(tpc_pkg::OFS_VAL_B, 32'h0000_0004);
    rdc(tpc_pkg::OFS_RIS, 32'h0000_0000);
    chain_trig_in <= 1'b1;
    @(posedge clk);
    chain_trig_in <= 1'b0;
    wait_ris(32'h0000_0101);
    chk32(rd & 32'h0000_0101, 32'h0000_0101);
    // Capture edges on the first half for edge codes 0 to 2, with a match on the first count.
    for (int e = 0; e < 3; e++) begin
      wr(tpc_pkg::OFS_CTRL_CLR, 32'h0003_ffff);
      wr(tpc_pkg::OFS_LOAD_A, 32'h0000_0005);
      wr(tpc_pkg::OFS_MATCH_A, 32'h0000_0004);
      wr(tpc_pkg::OFS_ICLR, 32'h0000_07ff);
      wr(tpc_pkg::OFS_CTRL_SET, 32'h0000_0041 | (32'(e) << 4));
      cap_a_in <= 1'b1;
      repeat (4) @(posedge clk);
      apb(1'b0, tpc_pkg::OFS_RIS, 32'h0000_0000, rd, se);
      chk32(rd & 32'h0000_0606, (e == 1) ? 32'h0000_0000 : 32'h0000_0006);
      wr(tpc_pkg::OFS_ICLR, 32'h0000_07ff);
      cap_a_in <= 1'b0;
      repeat (4) @(posedge clk);
      apb(1'b0, tpc_pkg::OFS_RIS, 32'h0000_0000, rd, se);
      v1 = (e == 0) ? 32'h0000_0000 : ((e == 1) ? 32'h0000_0006 : 32'h0000_0004);
      chk32(rd & 32'h0000_0606, v1);
    end
    // Second half capture, set for both edges, raises only its own event flag on a rising edge.
    wr(tpc_pkg::OFS_CTRL_CLR, 32'h0003_ffff);
    wr(tpc_pkg::OFS_LOAD_B, 32'h0000_0005);
    wr(tpc_pkg::OFS_ICLR, 32'h0000_07ff);
    wr(tpc_pkg::OFS_CTRL_SET, 32'h0000_6100);
    cap_b_in <= 1'b1;
    repeat (4) @(posedge clk);
    rdc(tpc_pkg::OFS_RIS, 32'h0000_0400);
    // Joined width: the first half's location carries the whole load value.
    wr(tpc_pkg::OFS_CTRL_CLR, 32'h0003_ffff);
    wr(tpc_pkg::OFS_CTRL_SET, 32'h0001_0000);
    wr(tpc_pkg::OFS_LOAD_A, 32'h0001_0002);
    rdc(tpc_pkg::OFS_LOAD_A, 32'h0001_0002);
    wr(tpc_pkg::OFS_MATCH_A, 32'h0000_0001);
    wr(tpc_pkg::OFS_LOAD_A, 32'h0000_0003);
    wr(tpc_pkg::OFS_CTRL_SET, 32'h0002_0001);
    wait_ris(32'h0000_0009);
    chk32(rd & 32'h0000_010f, 32'h0000_0009);
    // Reset in mid-run brings the mask, control and load registers back.
    wr(tpc_pkg::OFS_IMASK, 32'h0000_070f);
    wr(tpc_pkg::OFS_CTRL_SET, 32'h0000_0001);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk1(irq, 1'b0);
    rdc(tpc_pkg::OFS_IMASK, 32'h0000_0000);
    rdc(tpc_pkg::OFS_CTRL, 32'h0000_0000);
    rdc(tpc_pkg::OFS_LOAD_A, 32'h0000_ffff);
    tally_and_finish();
  end
endmodule
